//--- shared/svd_pkg.sv
// Package: register map, field layout and constants of the supply-voltage detector bank
package svd_pkg;

    // Register indexes; byte address on the bus is four times the index
    localparam logic [14:0] IDX_ENABLE    = 15'h5100;
    localparam logic [14:0] IDX_THRESHOLD = 15'h5101;
    localparam logic [14:0] IDX_RESULT    = 15'h5102;
    localparam logic [14:0] IDX_MASK      = 15'h5103;
    localparam logic [14:0] IDX_FLAG      = 15'h5104;
    localparam int          ADR_LSB       = 2;
    localparam int          ADR_MSB       = 16;

    // Enable register fields
    localparam int KEY_MSB = 7;
    localparam int KEY_LSB = 4;
    localparam int MD_MSB  = 3;
    localparam int MD_LSB  = 1;
    localparam int EN_BIT  = 0;

    // Threshold configuration fields
    localparam int SEL_BIT = 7;
    localparam int SC_MSB  = 6;
    localparam int SC_LSB  = 5;
    localparam int TC_MSB  = 4;
    localparam int TC_LSB  = 0;

    // Single-bit registers sit in bit 0
    localparam int LOW_BIT = 0;

    // Reset values and codes
    localparam logic [3:0] RESET_KEY     = 4'ha;
    localparam logic [3:0] KEY_RST       = 4'h0;
    localparam logic [2:0] MD_CONT       = 3'h0;
    localparam logic [2:0] MD_RST        = 3'h0;
    localparam logic [1:0] SC_RST        = 2'h0;
    localparam logic [4:0] TC_RST        = 5'h00;
    localparam logic [4:0] TC_FIRST      = 5'h0e;
    localparam logic [4:0] TC_LAST       = 5'h1a;
    localparam logic       SEL_SUPPLY    = 1'b0;

    // Shortest intermittent interval as a power-of-two shift of detector clock cycles (128), interval counter width, low-count ceiling
    localparam int          BASE_SHIFT   = 7;
    localparam int          IVL_W        = 14;
    localparam logic [2:0]  LOWCNT_MAX   = 3'h7;

    // Detection modes
    typedef enum logic [2:0] {
        SVD_OFF   = 3'b001,
        SVD_CONT  = 3'b010,
        SVD_INTER = 3'b100
    } svd_mode_t;

endpackage : svd_pkg

//--- src/svd_regs.sv
// Supply-voltage detector register bank with Wishbone slave and event logic
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module svd_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [16:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Analog side
    input  wire logic        comparator_below_i,
    input  wire logic        detector_clock_tick_i,
    output logic             detector_enable_o,
    output logic             monitor_source_select_o,
    output logic [4:0]       threshold_code_o,
    // System side
    output logic             irq_o,
    output logic             chip_reset_o
);

    // All state of the block
    typedef struct packed {
        logic                            ack;
        logic [31:0]                     rdata;
        logic                            sync1;
        logic                            sync2;
        svd_pkg::svd_mode_t              mode;
        logic [3:0]                      reset_key;
        logic [2:0]                      interval;
        logic                            enable;
        logic                            source_sel;
        logic [1:0]                      low_sample_count;
        logic [4:0]                      threshold_code;
        logic                            result;
        logic                            irq_enable;
        logic                            irq_flag;
        logic [svd_pkg::IVL_W-1:0]       ivl_cnt;
        logic [2:0]                      low_cnt;
        logic                            chip_reset;
    } svd_state_t;

    svd_state_t s_q;
    svd_state_t s_d;

    logic [14:0]               reg_idx;
    logic                      req;
    logic                      wr_fire;
    logic                      lane0;
    logic [7:0]                wbyte;
    logic                      set_evt;
    logic                      sample_evt;
    logic [svd_pkg::IVL_W-1:0] ivl_last;
    logic [2:0]                low_next;
    logic [2:0]                low_need;

    // Address decode and write timing: a write lands on the edge where ack is seen
    assign reg_idx = adr_i[svd_pkg::ADR_MSB:svd_pkg::ADR_LSB];
    assign req     = cyc_i & stb_i;
    assign wr_fire = req & we_i & s_q.ack;
    assign lane0   = sel_i[0];
    assign wbyte   = dat_i[7:0];

    // Ticks arrive as one-cycle pulses; a lost tick only stretches the interval
    // Counter is sized for the longest interval, shorter codes end earlier
    // Interval end: 128 shifted by code minus one, counted in detector ticks
    assign ivl_last = (svd_pkg::IVL_W'(1) << (svd_pkg::BASE_SHIFT
                      + int'(s_q.interval) - 1)) - svd_pkg::IVL_W'(1);
    assign low_need = {1'b0, s_q.low_sample_count} + 3'h1;
    assign low_next = (s_q.low_cnt == svd_pkg::LOWCNT_MAX) ? s_q.low_cnt
                      : s_q.low_cnt + 3'h1;
    assign sample_evt = (s_q.mode == svd_pkg::SVD_INTER) & detector_clock_tick_i
                        & (s_q.ivl_cnt == ivl_last);

    // Next-state logic for the whole block
    always_comb begin
        s_d     = s_q;
        set_evt = 1'b0;

        // Two-flop synchroniser on the analog output
        s_d.sync1 = comparator_below_i;
        s_d.sync2 = s_q.sync1;

        // Bus handshake; ack drops the cycle after it was given
        s_d.ack = req & ~s_q.ack;
        if (req & ~s_q.ack) begin
            s_d.rdata = 32'h0000_0000;
            case (reg_idx)
                svd_pkg::IDX_ENABLE: begin
                    s_d.rdata[svd_pkg::KEY_MSB:svd_pkg::KEY_LSB] = s_q.reset_key;
                    s_d.rdata[svd_pkg::MD_MSB:svd_pkg::MD_LSB]   = s_q.interval;
                    s_d.rdata[svd_pkg::EN_BIT]                   = s_q.enable;
                end
                svd_pkg::IDX_THRESHOLD: begin
                    s_d.rdata[svd_pkg::SEL_BIT]                = s_q.source_sel;
                    s_d.rdata[svd_pkg::SC_MSB:svd_pkg::SC_LSB] = s_q.low_sample_count;
                    s_d.rdata[svd_pkg::TC_MSB:svd_pkg::TC_LSB] = s_q.threshold_code;
                end
                svd_pkg::IDX_RESULT: s_d.rdata[svd_pkg::LOW_BIT] = s_q.result;
                svd_pkg::IDX_MASK:   s_d.rdata[svd_pkg::LOW_BIT] = s_q.irq_enable;
                svd_pkg::IDX_FLAG:   s_d.rdata[svd_pkg::LOW_BIT] = s_q.irq_flag;
                default:             s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Detection by mode
        case (s_q.mode)
            svd_pkg::SVD_OFF: begin
                s_d.ivl_cnt = '0;
                s_d.low_cnt = '0;
            end
            svd_pkg::SVD_CONT: begin
                s_d.result = s_q.sync2;
                if (s_q.sync2 & ~s_q.result) begin
                    set_evt = 1'b1;
                end
            end
            svd_pkg::SVD_INTER: begin
                if (detector_clock_tick_i) begin
                    s_d.ivl_cnt = sample_evt ? '0 : s_q.ivl_cnt + svd_pkg::IVL_W'(1);
                end
                if (sample_evt) begin
                    s_d.result = s_q.sync2;
                    if (s_q.sync2) begin
                        s_d.low_cnt = low_next;
                        if (low_next == low_need && s_q.low_cnt != low_need) begin
                            set_evt = 1'b1;
                        end
                    end else begin
                        s_d.low_cnt = '0;
                    end
                end
            end
            default: s_d.mode = svd_pkg::SVD_OFF;
        endcase

        // Stopping an intermittent run leaves a real result undefined; capturing the
        // synchronised bit gives software a defined value instead
        // Register writes, low byte lane only
        if (wr_fire & lane0) begin
            case (reg_idx)
                svd_pkg::IDX_ENABLE: begin
                    s_d.reset_key = wbyte[svd_pkg::KEY_MSB:svd_pkg::KEY_LSB];
                    s_d.interval  = wbyte[svd_pkg::MD_MSB:svd_pkg::MD_LSB];
                    s_d.enable    = wbyte[svd_pkg::EN_BIT];
                    if (s_q.enable & ~wbyte[svd_pkg::EN_BIT]) begin
                        s_d.result = s_q.sync2;
                    end
                end
                svd_pkg::IDX_THRESHOLD: begin
                    s_d.source_sel       = wbyte[svd_pkg::SEL_BIT];
                    s_d.low_sample_count = wbyte[svd_pkg::SC_MSB:svd_pkg::SC_LSB];
                    s_d.threshold_code   = wbyte[svd_pkg::TC_MSB:svd_pkg::TC_LSB];
                end
                svd_pkg::IDX_MASK: s_d.irq_enable = wbyte[svd_pkg::LOW_BIT];
                svd_pkg::IDX_FLAG: begin
                    if (wbyte[svd_pkg::LOW_BIT]) begin
                        s_d.irq_flag = 1'b0;
                    end
                end
                default: s_d.irq_enable = s_q.irq_enable;
            endcase
        end

        // Mode follows enable and interval; a restart clears the counters
        if (~s_d.enable) begin
            s_d.mode = svd_pkg::SVD_OFF;
        end else if (s_d.interval == svd_pkg::MD_CONT) begin
            s_d.mode = svd_pkg::SVD_CONT;
        end else begin
            s_d.mode = svd_pkg::SVD_INTER;
        end
        if (s_d.mode != s_q.mode) begin
            s_d.ivl_cnt = '0;
            s_d.low_cnt = '0;
        end

        // Set beats a same-cycle clear
        if (set_evt) begin
            s_d.irq_flag = 1'b1;
        end
        // With the key armed, every set event pulses the reset, even with the flag already high
        s_d.chip_reset = set_evt & (s_q.reset_key == svd_pkg::RESET_KEY);
    end

    // State register; reset clears the result bit and every other field except the mode, which loads SVD_OFF
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q                  <= '0;
            s_q.mode             <= svd_pkg::SVD_OFF;
            s_q.reset_key        <= svd_pkg::KEY_RST;
            s_q.interval         <= svd_pkg::MD_RST;
            s_q.source_sel       <= svd_pkg::SEL_SUPPLY;
            s_q.low_sample_count <= svd_pkg::SC_RST;
            s_q.threshold_code   <= svd_pkg::TC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign dat_o                   = s_q.rdata;
    assign ack_o                   = s_q.ack;
    assign detector_enable_o       = s_q.enable;
    assign monitor_source_select_o = s_q.source_sel;
    assign threshold_code_o        = s_q.threshold_code;
    assign irq_o                   = s_q.irq_flag & s_q.irq_enable;
    assign chip_reset_o            = s_q.chip_reset;

    // Checks
    a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == (s_q.irq_flag & s_q.irq_enable))
        else $error("interrupt line does not follow flag and enable");

    a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire & lane0 & reg_idx == svd_pkg::IDX_FLAG & dat_i[0] & ~set_evt)
        |=> ~s_q.irq_flag)
        else $error("write of one did not clear the flag");

    a_flag_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.irq_flag & ~(wr_fire & lane0 & reg_idx == svd_pkg::IDX_FLAG & dat_i[0]))
        |=> s_q.irq_flag)
        else $error("flag dropped without a clearing write");

    a_cont_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == svd_pkg::SVD_CONT & s_q.sync2 & ~s_q.result) |=> s_q.irq_flag)
        else $error("continuous low did not raise the flag");

    a_sync_path: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == svd_pkg::SVD_CONT && $past(s_q.mode) == svd_pkg::SVD_CONT)
        |-> s_q.result == $past(comparator_below_i, 3))
        else $error("result not fed through two synchroniser stages");

    a_hold_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == svd_pkg::SVD_OFF & ~s_d.enable) |=> $stable(s_q.result))
        else $error("result changed while detection was off");

    a_reset_key: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_q.irq_flag) |-> chip_reset_o == ($past(s_q.reset_key) == svd_pkg::RESET_KEY))
        else $error("chip reset does not follow the key on a flag set");

    a_inter_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (sample_evt & ~s_q.sync2) |=> s_q.low_cnt == 3'h0)
        else $error("normal sample did not restart the low count");

    a_mode_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.enable & s_q.interval == svd_pkg::MD_CONT) |-> s_q.mode == svd_pkg::SVD_CONT)
        else $error("continuous interval did not select continuous mode");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> ~ack_o)
        else $error("ack held for more than one cycle");

    a_ack_req: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> $past(cyc_i & stb_i))
        else $error("ack given without a request");

    // Register writes land on the edge where ack is seen
    a_select_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire & lane0 & reg_idx == svd_pkg::IDX_THRESHOLD)
        |=> monitor_source_select_o == $past(dat_i[svd_pkg::SEL_BIT]))
        else $error("source select did not take the written bit");

    a_code_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire & lane0 & reg_idx == svd_pkg::IDX_THRESHOLD)
        |=> threshold_code_o == $past(dat_i[svd_pkg::TC_MSB:svd_pkg::TC_LSB]))
        else $error("threshold code did not take the written field");

    a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire & lane0 & reg_idx == svd_pkg::IDX_MASK)
        |=> s_q.irq_enable == $past(dat_i[svd_pkg::LOW_BIT]))
        else $error("interrupt enable did not take the written bit");

    a_result_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire & lane0 & reg_idx == svd_pkg::IDX_RESULT & s_q.mode == svd_pkg::SVD_OFF)
        |=> $stable(s_q.result))
        else $error("write reached the read-only result");

    a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> dat_o[31:8] == 24'h00_0000)
        else $error("unused read data bits not zero");

    // Result moves only on a sample, a continuous cycle or a stop
    a_inter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == svd_pkg::SVD_INTER & ~sample_evt & s_d.enable) |=> $stable(s_q.result))
        else $error("intermittent result moved between samples");

    a_inter_sample: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_evt |=> s_q.result == $past(s_q.sync2))
        else $error("intermittent sample not loaded into the result");

    a_stop_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.enable & ~s_d.enable) |=> s_q.result == $past(s_q.sync2))
        else $error("stopping did not capture the final comparison");

    a_off_counters: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == svd_pkg::SVD_OFF) |-> (s_q.ivl_cnt == '0 && s_q.low_cnt == '0))
        else $error("counters not cleared while detection is stopped");

    a_inter_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == svd_pkg::SVD_INTER & ~sample_evt & ~s_q.irq_flag) |=> ~s_q.irq_flag)
        else $error("intermittent flag set away from a sample");

    a_first_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (sample_evt & s_q.sync2 & s_q.low_cnt == '0 & s_q.low_sample_count == '0)
        |=> s_q.irq_flag)
        else $error("single low sample did not raise the flag");

    a_cont_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == svd_pkg::SVD_CONT & ~(s_q.sync2 & ~s_q.result) & ~s_q.irq_flag)
        |=> ~s_q.irq_flag)
        else $error("continuous flag set without a rising result");

    // Reset output is tied to the key as it stood before the set event
    a_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        chip_reset_o |-> (s_q.irq_flag && $past(s_q.reset_key) == svd_pkg::RESET_KEY))
        else $error("chip reset pulse without an armed key and a set flag");

endmodule : svd_regs

`default_nettype wire

//--- verification/threshold_config_model.sv
// Behavioural comparator and detector clock source facing the register bank
`timescale 1ns/1ps
`default_nettype none

module threshold_config_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic [4:0] threshold_i,
    input  wire logic [4:0] level_i,
    output logic            below_o,
    output logic            tick_o
);
    // Tick every second clock keeps the 128-tick interval short
    // Comparator off: output wanders so a held result is really held
    always_ff @(posedge clk_i) begin
        tick_o <= rst_i ? 1'b0 : ~tick_o;
        if (rst_i) begin
            below_o <= 1'b0;
        end else if (enable_i) begin
            below_o <= (level_i < threshold_i);
        end else begin
            below_o <= ~below_o;
        end
    end
endmodule : threshold_config_model

`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the detector register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [16:0] adr_i = 17'h0_0000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [4:0]  level = 5'h1f;
    logic [31:0] dat_o;
    logic        ack_o, below, tick, en_o, src_o, irq_o, chip_reset_o;
    logic [4:0]  code_o;
    logic [7:0]  q, d;
    logic [31:0] lfsr_q = 32'h0000_dc8e;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          pulses = 0;
    int          m [5];

    svd_regs u_svd_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .comparator_below_i(below), .detector_clock_tick_i(tick),
        .detector_enable_o(en_o), .monitor_source_select_o(src_o),
        .threshold_code_o(code_o), .irq_o(irq_o), .chip_reset_o(chip_reset_o));
    threshold_config_model u_threshold_config_model (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en_o),
        .threshold_i(code_o), .level_i(level), .below_o(below), .tick_o(tick));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Cycle count bounds the run; reset pulses counted for the key test
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (chip_reset_o === 1'b1) pulses <= pulses + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic [14:0] idx, input logic w, input logic [7:0] wd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h00_0000, wd};
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (w && idx >= svd_pkg::IDX_ENABLE && idx <= svd_pkg::IDX_MASK
            && idx != svd_pkg::IDX_RESULT) m[idx - svd_pkg::IDX_ENABLE] = wd;
    endtask : wb

    task automatic rd(input logic [14:0] idx, input string name, input logic [7:0] exp);
        wb(idx, 1'b0, 8'h00);
        check(name, q, exp);
    endtask : rd

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        foreach (m[i]) m[i] = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values of the configurable registers
        rd(svd_pkg::IDX_ENABLE, "enable", 8'h00);
        rd(svd_pkg::IDX_THRESHOLD, "threshold", 8'h00);
        rd(svd_pkg::IDX_MASK, "mask", 8'h00);
        rd(svd_pkg::IDX_FLAG, "flag", 8'h00);
        $display("test reset values done");
        // Random configurations, reserved codes kept as written; select changed only when off
        repeat (6) begin
            lfsr_q = lfsr(lfsr_q);
            wb(svd_pkg::IDX_THRESHOLD, 1'b1, lfsr_q[7:0]);
            rd(svd_pkg::IDX_THRESHOLD, "threshold", 8'(m[1]));
            check("source", {7'h00, src_o}, {7'h00, lfsr_q[7]});
            check("code", {3'h0, code_o}, {3'h0, lfsr_q[4:0]});
        end
        wb(svd_pkg::IDX_RESULT, 1'b1, 8'hff);
        rd(svd_pkg::IDX_RESULT, "result ro", 8'h00);
        wb(15'h5105, 1'b1, 8'hff);
        rd(15'h5105, "unmapped", 8'h00);
        $display("test configuration done");
        // Continuous mode: result, flag, mask, write one to clear
        wb(svd_pkg::IDX_THRESHOLD, 1'b1, 8'h14);
        level <= 5'h18;
        wb(svd_pkg::IDX_ENABLE, 1'b1, 8'h51);
        repeat (10) @(posedge clk_i);
        check("enable out", {7'h00, en_o}, 8'h01);
        rd(svd_pkg::IDX_RESULT, "result", 8'h00);
        // Start-up wander of the comparator may have set the flag; clear it first
        wb(svd_pkg::IDX_FLAG, 1'b1, 8'h01);
        rd(svd_pkg::IDX_FLAG, "flag", 8'h00);
        level <= 5'h10;
        repeat (10) @(posedge clk_i);
        rd(svd_pkg::IDX_RESULT, "result", 8'h01);
        rd(svd_pkg::IDX_FLAG, "flag", 8'h01);
        check("irq masked", {7'h00, irq_o}, 8'h00);
        wb(svd_pkg::IDX_MASK, 1'b1, 8'h01);
        @(posedge clk_i);
        check("irq", {7'h00, irq_o}, 8'h01);
        wb(svd_pkg::IDX_FLAG, 1'b1, 8'h00);
        rd(svd_pkg::IDX_FLAG, "flag", 8'h01);
        level <= 5'h18;
        repeat (10) @(posedge clk_i);
        rd(svd_pkg::IDX_RESULT, "result", 8'h00);
        wb(svd_pkg::IDX_FLAG, 1'b1, 8'h01);
        rd(svd_pkg::IDX_FLAG, "flag", 8'h00);
        check("irq", {7'h00, irq_o}, 8'h00);
        check("no reset", 8'(pulses), 8'h00);
        // Disabled detector keeps its last result
        level <= 5'h10;
        repeat (10) @(posedge clk_i);
        wb(svd_pkg::IDX_ENABLE, 1'b1, 8'h00);
        repeat (20) @(posedge clk_i);
        rd(svd_pkg::IDX_RESULT, "held", 8'h01);
        wb(svd_pkg::IDX_FLAG, 1'b1, 8'h01);
        $display("test continuous done");
        // Armed key; sample count ignored in continuous mode
        level <= 5'h18;
        wb(svd_pkg::IDX_THRESHOLD, 1'b1, 8'h74);
        wb(svd_pkg::IDX_ENABLE, 1'b1, 8'h01);
        // Arm only once settled, so start-up wander cannot fire a reset
        repeat (10) @(posedge clk_i);
        wb(svd_pkg::IDX_FLAG, 1'b1, 8'h01);
        wb(svd_pkg::IDX_ENABLE, 1'b1, 8'ha1);
        rd(svd_pkg::IDX_ENABLE, "enable", 8'(m[0]));
        rd(svd_pkg::IDX_FLAG, "flag", 8'h00);
        level <= 5'h10;
        repeat (10) @(posedge clk_i);
        rd(svd_pkg::IDX_FLAG, "flag", 8'h01);
        check("chip reset", 8'(pulses), 8'h01);
        $display("test reset key done");
        // Intermittent 128-tick interval: flag only after sc+1 lows
        for (int sc = 0; sc < 4; sc++) begin
            wb(svd_pkg::IDX_ENABLE, 1'b1, 8'h00);
            wb(svd_pkg::IDX_FLAG, 1'b1, 8'h01);
            d = {1'b0, 2'(sc), 5'h14};
            wb(svd_pkg::IDX_THRESHOLD, 1'b1, d);
            wb(svd_pkg::IDX_ENABLE, 1'b1, 8'h03);
            repeat (sc * 256 + 128) @(posedge clk_i);
            rd(svd_pkg::IDX_FLAG, "early", 8'h00);
            repeat (256) @(posedge clk_i);
            rd(svd_pkg::IDX_FLAG, "counted", 8'h01);
        end
        $display("test intermittent done");
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
